// File: hvf_fault_resp.sv
// fault response control for the high-voltage bus monitors
// assumes fault levels and pins are synchronous to core_clk;
// registers reached over apb, one 32-bit word per register
//////////////////////////////////////////////////////////////////////////////
// What this block does
// RL1: control register is one byte, read-write, cleared by reset
// RL2: bits 1:0 pick response to bus output overvoltage
// RL3: bits 3:2 pick response to bus output undervoltage
// RL4: bits 5:4 pick response to bus input overvoltage
// RL5: bits 7:6 pick response to bus input undervoltage
// RL6: fields apply only while global enable is one, else mode pins
// RL7: field 00 only flags the fault; switching keeps running
// RL8: field 01 stops switching, restarts 500 ms after fault clears
// RL9: field 10 stops switching until enable or chip enable toggles
// RL10: field 11 behaves exactly like 00
// RL11: output overvoltage sets status bit 4
// RL12: output undervoltage sets status bit 5
// RL13: input overvoltage sets status bit 6
// RL14: input undervoltage sets status bit 7
// RL15: any detected fault pulls the active-low fault output low
// RL16: hiccup timer counts only after clear, restarts if fault returns
// RL17: stop request is the OR of all hiccup and latch conditions
//
// Decided for this implementation: the APB interface to the registers.
module hvf_fault_resp
	import hvf_pkg::*;
#(
	parameter int unsigned HiccupCycles = HICCUP_CYC
) (
	input  wire logic                     core_clk,
	input  wire logic                     resetn,
	input  wire hvf_pkg::hvf_apb_req_t    apbReq,
	output hvf_pkg::hvf_apb_rsp_t         apbRsp,
	input  wire logic [hvf_pkg::NUM_FAULT-1:0] highVoltageBusFault,
	input  wire logic [1:0]               modeResp,
	input  wire logic                     pwmEnable,
	input  wire logic                     chipEnable,
	output logic                          pwmStop,
	output logic                          fault_status_out_n,
	output logic                          irq
);
	import hvf_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic regHit(
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        idx
	);
		regHit = (addr == {2'b00, idx, 2'b00});
	endfunction : regHit

	function automatic logic isHiccup(input logic [1:0] resp);
		isHiccup = (resp == RESP_HICCUP);
	endfunction : isHiccup

	function automatic logic isLatch(input logic [1:0] resp);
		isLatch = (resp == RESP_LATCH);
	endfunction : isLatch

	//////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [7:0]           ctrl;
		logic                 glbEn;
		logic [NUM_FAULT-1:0] status;
		logic [NUM_FAULT-1:0] irqEn;
		logic [NUM_FAULT-1:0] latched;
		logic                 stop;
		logic                 faultN;
		logic                 irq;
		hvf_apb_rsp_t         rsp;
	} hvf_top_st_t;

	logic                 rstSyncN;
	hvf_top_st_t          state_r;
	hvf_top_st_t          state_nxt;
	logic [NUM_FAULT-1:0] hiccupArmed;
	logic [NUM_FAULT-1:0] hiccupHalt;
	logic [NUM_FAULT-1:0] latchArmed;

	hvf_reset_sync uResetSync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.rstSyncN (rstSyncN)
	);

	//////////////////////////////////////////////////////////////////////////
	// per-fault response selection

	genvar gi;
	generate
		for (gi = 0; gi < NUM_FAULT; gi++) begin : gFault
			logic [1:0] field;
			logic [1:0] resp;

			// field gi covers ctrl[2gi+1:2gi]
			assign field = state_r.ctrl[FIELD_W*gi +: FIELD_W]; // RL2 RL3 RL4 RL5
			// mode pins rule while the global enable is off
			assign resp = state_r.glbEn ? field : modeResp; // RL6
			// flag-only codes 00 and 11 arm neither path
			assign hiccupArmed[gi] = highVoltageBusFault[gi]
				& isHiccup(resp); // RL7 RL10
			assign latchArmed[gi] = highVoltageBusFault[gi]
				& isLatch(resp); // RL9

			hvf_hiccup_timer #(
				.HiccupCycles (HiccupCycles)
			) uTimer (
				.core_clk (core_clk),
				.rstSyncN (rstSyncN),
				.armed    (hiccupArmed[gi]),
				.halt     (hiccupHalt[gi])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// next state

	logic                 setup;
	logic                 access;
	logic                 hitGlb;
	logic                 hitCtrl;
	logic                 hitStat;
	logic                 hitClr;
	logic                 hitIrqEn;
	logic                 mapped;
	logic [NUM_FAULT-1:0] clrMask;
	logic                 relatch;

	always_comb begin
		state_nxt = state_r;

		setup    = apbReq.psel & ~apbReq.penable;
		access   = apbReq.psel & apbReq.penable & state_r.rsp.pready;
		hitGlb   = regHit(apbReq.paddr, GLB_IDX);
		hitCtrl  = regHit(apbReq.paddr, CTRL_IDX);
		hitStat  = regHit(apbReq.paddr, STAT_IDX);
		hitClr   = regHit(apbReq.paddr, CLR_IDX);
		hitIrqEn = regHit(apbReq.paddr, IRQEN_IDX);
		mapped   = hitGlb | hitCtrl | hitStat | hitClr | hitIrqEn;
		clrMask  = '0;

		// no wait state: pready rises in the first access cycle
		state_nxt.rsp.pready  = setup;
		state_nxt.rsp.pslverr = setup & ~mapped;
		if (setup) begin
			state_nxt.rsp.prdata = '0;
			if (!apbReq.pwrite) begin
				if (hitGlb) begin
					state_nxt.rsp.prdata[GLB_EN_BIT] = state_r.glbEn;
				end
				if (hitCtrl) begin
					state_nxt.rsp.prdata[7:0] = state_r.ctrl; // RL1
				end
				if (hitStat) begin
					state_nxt.rsp.prdata[STAT_LSB +: NUM_FAULT] =
						state_r.status;
				end
				if (hitIrqEn) begin
					state_nxt.rsp.prdata[NUM_FAULT-1:0] = state_r.irqEn;
				end
			end
		end

		// writes take effect at the completing edge only
		if (access && apbReq.pwrite) begin
			if (hitGlb) begin
				state_nxt.glbEn = apbReq.pwdata[GLB_EN_BIT];
			end
			if (hitCtrl) begin
				state_nxt.ctrl = apbReq.pwdata[7:0]; // RL1
			end
			if (hitIrqEn) begin
				state_nxt.irqEn = apbReq.pwdata[NUM_FAULT-1:0];
			end
			if (hitClr) begin
				clrMask = apbReq.pwdata[STAT_LSB +: NUM_FAULT];
			end
		end

		// sticky status: a fault in the clearing cycle keeps its bit
		state_nxt.status = (state_r.status & ~clrMask)
			| highVoltageBusFault; // RL11 RL12 RL13 RL14

		// latch-off holds until either enable pin is taken low
		relatch = pwmEnable & chipEnable;
		state_nxt.latched = ((relatch ? state_r.latched : '0))
			| latchArmed; // RL9

		state_nxt.stop = (|hiccupHalt) | (|hiccupArmed)
			| (|state_nxt.latched); // RL17 RL8

		// flag stays low while any fault is present or still recorded
		state_nxt.faultN = ~((|highVoltageBusFault)
			| (|state_nxt.status)); // RL15

		state_nxt.irq = |(state_nxt.status & state_nxt.irqEn);
	end

	//////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge core_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_r.ctrl    <= CTRL_RST; // RL1
			state_r.glbEn   <= GLB_RST;
			state_r.status  <= '0;
			state_r.irqEn   <= IRQEN_RST[NUM_FAULT-1:0];
			state_r.latched <= '0;
			state_r.stop    <= 1'b0;
			state_r.faultN  <= 1'b1;
			state_r.irq     <= 1'b0;
			state_r.rsp     <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign apbRsp             = state_r.rsp;
	assign pwmStop            = state_r.stop;
	assign fault_status_out_n = state_r.faultN;
	assign irq                = state_r.irq;

endmodule : hvf_fault_resp

// File: hvf_pkg.sv
// constants and carrier types for the high-voltage bus fault response block
// assumes a single 125 MHz core clock and an apb master with 12-bit addresses
package hvf_pkg;

	localparam int unsigned ADDR_W     = 12;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned NUM_FAULT  = 4;

	// register indices; byte address is four times the index
	localparam logic [7:0] GLB_IDX    = 8'hB0;
	localparam logic [7:0] CTRL_IDX   = 8'hB2;
	localparam logic [7:0] STAT_IDX   = 8'hD2;
	localparam logic [7:0] CLR_IDX    = 8'hD8;
	localparam logic [7:0] IRQEN_IDX  = 8'hD9;

	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] IRQEN_RST  = 8'h00;
	localparam logic       GLB_RST    = 1'b0;
	localparam int unsigned GLB_EN_BIT = 7;
	localparam int unsigned STAT_LSB   = 4;
	localparam int unsigned FIELD_W    = 2;

	// fault index: field i sits at ctrl[2i+1:2i], status at bit STAT_LSB+i
	localparam int unsigned F_OUT_OV = 0;
	localparam int unsigned F_OUT_UV = 1;
	localparam int unsigned F_IN_OV  = 2;
	localparam int unsigned F_IN_UV  = 3;

	// hiccup restart delay
	localparam int unsigned HICCUP_MS  = 500;
	localparam int unsigned CLK_HZ     = 125_000_000;
	localparam int unsigned HICCUP_CYC = HICCUP_MS * (CLK_HZ / 1000);
	localparam int unsigned CNT_W      = 26;

	typedef enum logic [1:0] {
		RESP_FLAG   = 2'b00,
		RESP_HICCUP = 2'b01,
		RESP_LATCH  = 2'b10,
		RESP_FLAG2  = 2'b11
	} hvf_resp_t;

	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [DATA_W-1:0] pwdata;
	} hvf_apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} hvf_apb_rsp_t;

endpackage : hvf_pkg

// File: hvf_reset_sync.sv
// two-stage release synchroniser for the active-low reset
// assumes resetn may fall at any time; release is taken on core_clk
module hvf_reset_sync (
	input  wire logic core_clk,
	input  wire logic resetn,
	output logic      rstSyncN
);
	import hvf_pkg::*;

	typedef struct packed {
		logic stage1;
		logic stage2;
	} hvf_rsync_st_t;

	hvf_rsync_st_t state_r;
	hvf_rsync_st_t state_nxt;

	always_comb begin
		state_nxt.stage1 = 1'b1;
		state_nxt.stage2 = state_r.stage1;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign rstSyncN = state_r.stage2;

endmodule : hvf_reset_sync

// File: hvf_hiccup_timer.sv
// restart timer for one fault in hiccup mode
// assumes armed is high while the fault is present and hiccup is chosen
module hvf_hiccup_timer #(
	parameter int unsigned HiccupCycles = hvf_pkg::HICCUP_CYC
) (
	input  wire logic core_clk,
	input  wire logic rstSyncN,
	input  wire logic armed,
	output logic      halt
);
	import hvf_pkg::*;

	typedef enum logic [1:0] {
		T_IDLE  = 2'b00,
		T_HALT  = 2'b01,
		T_COUNT = 2'b10
	} hvf_tstate_t;

	typedef struct packed {
		hvf_tstate_t      fsm;
		logic [CNT_W-1:0] cnt;
		logic             halt;
	} hvf_timer_st_t;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(HiccupCycles - 1);

	hvf_timer_st_t state_r;
	hvf_timer_st_t state_nxt;

	always_comb begin
		state_nxt = state_r;
		case (state_r.fsm)
			T_IDLE: begin
				if (armed) begin
					state_nxt.fsm = T_HALT;
				end
			end
			T_HALT: begin
				state_nxt.cnt = '0;
				if (!armed) begin
					state_nxt.fsm = T_COUNT; // RL16
				end
			end
			T_COUNT: begin
				if (armed) begin
					state_nxt.fsm = T_HALT; // RL16
					state_nxt.cnt = '0;
				end else if (state_r.cnt == LAST) begin
					state_nxt.fsm = T_IDLE; // RL8
				end else begin
					state_nxt.cnt = state_r.cnt + 1'b1;
				end
			end
			default: begin
				state_nxt.fsm = T_IDLE;
			end
		endcase
		state_nxt.halt = (state_nxt.fsm != T_IDLE);
	end

	always_ff @(posedge core_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_r <= '{fsm: T_IDLE, cnt: '0, halt: 1'b0};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign halt = state_r.halt;

endmodule : hvf_hiccup_timer

// File: hvf_fault_resp_monitor.sv
// port assertions for the fault response block, bound below
// assumes one clock domain and faults raised well after reset
module hvf_fault_resp_monitor
	import hvf_pkg::*;
(
	input wire logic                           core_clk,
	input wire logic                           resetn,
	input wire hvf_pkg::hvf_apb_req_t          apbReq,
	input wire hvf_pkg::hvf_apb_rsp_t          apbRsp,
	input wire logic [hvf_pkg::NUM_FAULT-1:0]  highVoltageBusFault,
	input wire logic                           pwmStop,
	input wire logic                           fault_status_out_n,
	input wire logic                           irq
);
	//////////////////////////////////////////////////////////////////////////
	wire logic anyF = |highVoltageBusFault;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	property p_rdy;
		apbReq.psel && !apbReq.penable |=> apbRsp.pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_one; apbRsp.pready |=> !apbRsp.pready; endproperty
	a_one: assert property (p_one) else $error("ready held");
	property p_err; apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == '0;
	endproperty
	a_err: assert property (p_err) else $error("bad error answer");
	property p_flag; anyF |-> ##1 !fault_status_out_n; endproperty
	a_flag: assert property (p_flag) else $error("flag not low");
	property p_flagc; $fell(fault_status_out_n) |-> $past(anyF); endproperty
	a_flagc: assert property (p_flagc) else $error("flag without fault");
	property p_stopc; $rose(pwmStop) |-> $past(anyF); endproperty
	a_stopc: assert property (p_stopc) else $error("stop without fault");
	property p_hold; pwmStop && anyF |=> pwmStop; endproperty
	a_hold: assert property (p_hold) else $error("stop dropped early");
	property p_irq; !anyF && fault_status_out_n |=> !irq; endproperty
	a_irq: assert property (p_irq) else $error("irq without status");
	c_hic: cover property ($fell(pwmStop));
	c_err: cover property (apbRsp.pslverr);
	c_irq: cover property ($rose(irq));
endmodule : hvf_fault_resp_monitor

bind hvf_fault_resp hvf_fault_resp_monitor mon_u (.core_clk(core_clk),
	.resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp),
	.highVoltageBusFault(highVoltageBusFault), .pwmStop(pwmStop),
	.fault_status_out_n(fault_status_out_n), .irq(irq));

// File: hvf_fault_resp_tb.sv
// self-checking bench for the fault response block
// assumes the monitor is bound; hiccup delay shortened to 20 cycles
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import hvf_pkg::*;
	localparam int unsigned HC = 20;
	localparam logic [11:0] A_GLB = {2'h0, GLB_IDX, 2'h0};
	localparam logic [11:0] A_CTRL = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, STAT_IDX, 2'h0};
	localparam logic [11:0] A_CLR = {2'h0, CLR_IDX, 2'h0};
	localparam logic [11:0] A_IEN = {2'h0, IRQEN_IDX, 2'h0};
	logic         core_clk = 1'b0;
	logic         resetn = 1'b0;
	hvf_apb_req_t req = '0;
	hvf_apb_rsp_t rsp;
	logic [3:0]   flt = 4'h0;
	logic [1:0]   modeResp = 2'h0;
	logic         pwmEn = 1'b1;
	logic         chipEn = 1'b1;
	logic         pwmStop, flagN, irq, rerr;
	logic [31:0]  rdat;
	int           n_mismatch = 0;
	int           check_count = 0;
	// {fault index, field code, stops}
	logic [4:0]   rows [8] = '{5'h00, 5'h0B, 5'h15, 5'h1E,
		5'h05, 5'h0E, 5'h10, 5'h1B};
	//////////////////////////////////////////////////////////////////////////
	always #4 core_clk = ~core_clk;
	hvf_fault_resp #(.HiccupCycles(HC)) dut_u (.core_clk(core_clk),
		.resetn(resetn), .apbReq(req), .apbRsp(rsp),
		.highVoltageBusFault(flt), .modeResp(modeResp), .pwmEnable(pwmEn),
		.chipEnable(chipEn), .pwmStop(pwmStop),
		.fault_status_out_n(flagN), .irq(irq));
	task automatic final_report;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic chkb(input string nm, input logic e, g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s exp %b got %b", nm, e, g);
		end
	endtask : chkb
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask : tick
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge core_clk);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		if (rsp.pready !== 1'b1) begin
			n_mismatch++;
			final_report();
		end
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb
	task automatic setf(input logic [3:0] v);
		@(posedge core_clk);
		flt <= v;
	endtask : setf
	initial begin
		tick(20);
		resetn <= 1'b1;
		tick(3);
		apb(1'b0, A_CTRL, 32'h0);
		chk("ctrl", 32'h0, rdat);
		apb(1'b1, A_CTRL, 32'hA5);
		apb(1'b1, A_STAT, 32'hF0);
		apb(1'b0, A_CTRL, 32'h0);
		chk("ctrl", 32'hA5, rdat);
		apb(1'b0, A_STAT, 32'h0);
		chk("status", 32'h0, rdat);
		apb(1'b0, 12'h004, 32'h0);
		chkb("slverr", 1'b1, rerr);
		apb(1'b1, A_GLB, 32'h80);
		apb(1'b0, A_GLB, 32'h0);
		chk("glbEn", 32'h80, rdat);
		for (int i = 0; i < 8; i++) begin
			logic [1:0] f;
			logic [1:0] c;
			logic s;
			f = rows[i][4:3];
			c = rows[i][2:1];
			s = rows[i][0];
			apb(1'b1, A_CTRL, 32'(c) << (2 * f));
			setf(4'h1 << f);
			tick(2);
			chkb("stop", s, pwmStop);
			chkb("flag", 1'b0, flagN);
			apb(1'b0, A_STAT, 32'h0);
			chk("status", 32'h10 << f, rdat);
			setf(4'h0);
			tick(10);
			chkb("stop", s, pwmStop);
			tick(HC + 10);
			chkb("stop", c == 2'h2, pwmStop);
			pwmEn <= 1'b0;
			tick(2);
			pwmEn <= 1'b1;
			tick(1);
			chkb("stop", 1'b0, pwmStop);
			apb(1'b1, A_CLR, 32'hF0);
			tick(2);
			chkb("flag", 1'b1, flagN);
		end
		// fault returning mid-count must restart the wait
		apb(1'b1, A_CTRL, 32'h01);
		setf(4'h1);
		tick(3);
		setf(4'h0);
		tick(15);
		setf(4'h1);
		setf(4'h0);
		tick(15);
		chkb("stop", 1'b1, pwmStop);
		tick(HC);
		chkb("stop", 1'b0, pwmStop);
		apb(1'b1, A_IEN, 32'h1);
		apb(1'b1, A_GLB, 32'h0);
		apb(1'b1, A_CTRL, 32'h02);
		tick(2);
		chkb("irq", 1'b1, irq);
		apb(1'b1, A_IEN, 32'h0);
		tick(2);
		chkb("irq", 1'b0, irq);
		setf(4'h1);
		tick(2);
		chkb("stop", 1'b0, pwmStop);
		setf(4'h0);
		modeResp <= 2'h2;
		setf(4'h1);
		setf(4'h0);
		tick(2);
		chkb("stop", 1'b1, pwmStop);
		chipEn <= 1'b0;
		tick(2);
		chipEn <= 1'b1;
		tick(1);
		chkb("stop", 1'b0, pwmStop);
		// hiccup chosen by the mode pins
		modeResp <= 2'h1;
		setf(4'h2);
		tick(2);
		chkb("stop", 1'b1, pwmStop);
		setf(4'h0);
		tick(HC + 10);
		chkb("stop", 1'b0, pwmStop);
		// reset in mid-run with a latch-off pending and ctrl written
		modeResp <= 2'h2;
		setf(4'h8);
		setf(4'h0);
		tick(2);
		chkb("stop", 1'b1, pwmStop);
		apb(1'b1, A_CTRL, 32'hFF);
		resetn <= 1'b0;
		tick(3);
		chkb("stop", 1'b0, pwmStop);
		chkb("flag", 1'b1, flagN);
		resetn <= 1'b1;
		tick(3);
		apb(1'b0, A_CTRL, 32'h0);
		chk("ctrl", 32'h0, rdat);
		apb(1'b0, A_GLB, 32'h0);
		chk("glbEn", 32'h0, rdat);
		final_report();
	end
endmodule : testbench
